// ---- core/adc_ctl_pkg.sv ----
// constants for the converter control block: register map, field
// positions, reset values, trigger codes and rate limits.
// assumes a 16-bit register port and a 10 MHz system clock.
package adc_ctl_pkg;

  // ==========================================================
  // register port
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [3:0] OFF_CTRL_FIRST = 4'h0;
  localparam logic [3:0] OFF_CTRL_SECOND = 4'h1;
  localparam logic [3:0] OFF_CTRL_THIRD = 4'h2;
  localparam logic [3:0] OFF_PIN_LOW = 4'h3;
  localparam logic [3:0] OFF_PIN_HIGH = 4'h4;
  localparam logic [3:0] OFF_CH_SELECT = 4'h5;
  localparam logic [3:0] OFF_DMA_LEN = 4'h6;
  localparam logic [3:0] OFF_STATUS = 4'h7;
  localparam logic [3:0] OFF_RESULT = 4'h8;

  // ==========================================================
  // writable masks and reset values
  localparam logic [15:0] MASK_CTRL_FIRST = 16'hB7EC;
  localparam logic [15:0] MASK_CTRL_SECOND = 16'hE33C;
  localparam logic [15:0] MASK_CTRL_THIRD = 16'h1FFF;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_PIN = 16'h0000;
  localparam logic [3:0] RST_CH_SELECT = 4'h0;
  localparam logic [2:0] RST_DMA_LEN = 3'h0;

  // ==========================================================
  // field positions
  localparam int B_ON = 15;
  localparam int B_BUILD = 12;
  localparam int B_RES = 10;
  localparam int B_FORM = 8;
  localparam int B_SSRC = 5;
  localparam int B_SIMSAM = 3;
  localparam int B_ASAM = 2;
  localparam int B_SAMP = 1;
  localparam int B_DONE = 0;
  localparam int B_VREF = 13;
  localparam int B_CHPS = 8;
  localparam int B_PER_IRQ = 2;
  localparam int B_SAMC = 8;
  localparam int B_ADCS = 0;
  localparam int B_IRQ = 0;
  localparam int B_OVR = 1;
  localparam int B_PEND = 2;

  // ==========================================================
  // codes
  localparam logic [2:0] TRIG_SOFT = 3'h0;
  localparam logic [2:0] TRIG_EXT_PIN = 3'h1;
  localparam logic [2:0] TRIG_TMR_A = 3'h2;
  localparam logic [2:0] TRIG_TMR_B = 3'h4;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [1:0] FMT_SIGNED = 2'h1;
  localparam int N_INPUTS = 13;
  localparam int N_SH = 4;
  localparam int RES12_BITS = 12;
  localparam logic [3:0] MSB_10 = 4'h9;
  localparam logic [3:0] MSB_12 = 4'hB;

  // ==========================================================
  // rate limits
  localparam int CLK_KHZ = 10000;
  localparam int RATE10_KSPS = 1100;
  localparam int RATE12_KSPS = 500;
  localparam logic [4:0] MIN_PERIOD_10 =
    5'((CLK_KHZ + RATE10_KSPS - 1) / RATE10_KSPS);
  localparam logic [4:0] MIN_PERIOD_12 =
    5'((CLK_KHZ + RATE12_KSPS - 1) / RATE12_KSPS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV = 2'b10
  } state_t;

endpackage

// ---- core/sar_engine.sv ----
// successive-approximation bit engine: one bit trial per conversion
// clock period. assumes an external comparator that is high when the
// held input is at or above the trial code on the DAC.
`timescale 1ns/1ps
`default_nettype none

module sar_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic twelve,
  input wire logic [7:0] tad_div,
  input wire logic comp,
  output logic busy,
  output logic done,
  output logic [11:0] code,
  output logic [11:0] result
);
  import adc_ctl_pkg::*;

  // ==========================================================
  // trial sequencing
  logic [7:0] tad_cnt;
  logic [3:0] bit_idx;
  wire [3:0] msb = twelve ? MSB_12 : MSB_10;
  wire [11:0] bit_mask = 12'h001 << bit_idx;
  wire [11:0] kept = comp ? code : (code & ~bit_mask);
  wire [11:0] next_code = kept | (bit_mask >> 1);
  wire trial_end = busy && (tad_cnt == 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      tad_cnt <= 8'h00;
      bit_idx <= 4'h0;
      code <= 12'h000;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        tad_cnt <= tad_div;
        bit_idx <= msb;
        code <= 12'h001 << msb;
      end else if (busy) begin
        tad_cnt <= trial_end ? tad_div : tad_cnt - 8'h01;
        if (trial_end) begin
          // lsb decided: close out, park the dac at zero
          if (bit_idx == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
            result <= kept;
            code <= 12'h000;
          end else begin
            bit_idx <= bit_idx - 4'h1;
            code <= next_code;
          end
        end
      end
    end
  end

endmodule // sar_engine

`default_nettype wire

// ---- core/sar_adc_ctl.sv ----
// control logic of a 10/12-bit successive-approximation converter:
// registers, sample sequencing, result format, interrupt flag and
// dma request. assumes external analog mux, s/h, dac and comparator.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - resolution select bit picks 10-bit four s/h, default, or 12-bit one s/h
// - 10-bit mode samples up to four inputs simultaneously
// - 12-bit mode uses one s/h, converts one channel at a time
// - rate capped at 1.1 Msps 10-bit and 500 ksps 12-bit; 10-bit starts are held 10 clocks apart, 1 Msps at 10 MHz
// - input mux reaches analog inputs 0 to 12; reference inputs selectable
// - reference source chosen by second control bits 15:13
// - conversion clock derived from third control bits 7:0
// - second control bits 9:8 set number of s/h channels used
// - sequence set by first control bits 7:5 and third bits 12:8
// - result format chosen by first control bits 9:8
// - each interrupt flag setting raises one dma transfer request unless a request is still pending
// - samples-per-interrupt sets how often dma pointer advances
// - build bit set gives dma the sequential buffer address
// - build bit clear gives scatter/gather address from input and size
// - samples-per-interrupt sets conversions per interrupt flag
module sar_adc_ctl (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [adc_ctl_pkg::AW-1:0] ADDR,
  input wire logic [adc_ctl_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [adc_ctl_pkg::DW-1:0] RDATA,
  input wire logic COMP,
  output logic [adc_ctl_pkg::RES12_BITS-1:0] DAC_CODE,
  output logic [adc_ctl_pkg::N_SH-1:0] SH_SAMPLE,
  output logic [3:0] MUX_INPUT,
  output logic [1:0] SH_ROUTE,
  output logic [2:0] VREF_SEL,
  output logic [adc_ctl_pkg::N_INPUTS-1:0] PIN_ANALOG,
  input wire logic TRIG_EXT,
  input wire logic TRIG_TIMER_A,
  input wire logic TRIG_TIMER_B,
  output logic IRQ_FLAG,
  output logic DMA_REQ,
  input wire logic DMA_ACK,
  output logic [10:0] DMA_ADDR,
  output logic [adc_ctl_pkg::DW-1:0] DMA_DATA
);
  import adc_ctl_pkg::*;

  // ==========================================================
  // registers
  logic [15:0] ctrl_first;
  logic [15:0] ctrl_second;
  logic [15:0] ctrl_third;
  logic [15:0] pin_low;
  logic [15:0] pin_high;
  logic [3:0] ch0_sel;
  logic [2:0] dma_len;
  logic samp;
  logic done_bit;
  logic overrun;
  logic [15:0] result;
  state_t st;
  state_t next_st;

  // ==========================================================
  // field views
  wire adon = ctrl_first[B_ON];
  wire build_order = ctrl_first[B_BUILD];
  wire res12 = ctrl_first[B_RES];
  wire [1:0] form = ctrl_first[B_FORM +: 2];
  wire [2:0] ssrc = ctrl_first[B_SSRC +: 3];
  wire asam = ctrl_first[B_ASAM];
  wire simsam_eff = ctrl_first[B_SIMSAM] & ~res12;
  wire [1:0] chps = ctrl_second[B_CHPS +: 2];
  wire [3:0] per_irq = ctrl_second[B_PER_IRQ +: 4];
  wire [4:0] samc = ctrl_third[B_SAMC +: 5];
  wire [7:0] adcs = ctrl_third[B_ADCS +: 8];

  // ==========================================================
  // register port decode
  wire wr_first = WR && (ADDR == OFF_CTRL_FIRST);
  wire wr_second = WR && (ADDR == OFF_CTRL_SECOND);
  wire wr_third = WR && (ADDR == OFF_CTRL_THIRD);
  wire wr_pin_low = WR && (ADDR == OFF_PIN_LOW);
  wire wr_pin_high = WR && (ADDR == OFF_PIN_HIGH);
  wire wr_ch_sel = WR && (ADDR == OFF_CH_SELECT);
  wire wr_dma_len = WR && (ADDR == OFF_DMA_LEN);
  wire wr_status = WR && (ADDR == OFF_STATUS);

  // resolution select is frozen while the converter runs, so a careless
  // write cannot flip the s/h layout under a live sequence
  wire [15:0] first_wr = (WDATA & MASK_CTRL_FIRST & ~16'h0400)
    | ((adon ? ctrl_first : WDATA) & 16'h0400);
  // simultaneous sampling reads zero in 12-bit mode
  wire [15:0] first_rd = (ctrl_first
    & ~({15'h0000, res12} << B_SIMSAM))
    | ({15'h0000, samp} << B_SAMP) | ({15'h0000, done_bit} << B_DONE);
  wire [15:0] status_rd = {13'h0000, DMA_REQ, overrun, IRQ_FLAG};
  wire [15:0] rd_mux =
    (ADDR == OFF_CTRL_FIRST) ? first_rd :
    (ADDR == OFF_CTRL_SECOND) ? ctrl_second :
    (ADDR == OFF_CTRL_THIRD) ? ctrl_third :
    (ADDR == OFF_PIN_LOW) ? pin_low :
    (ADDR == OFF_PIN_HIGH) ? pin_high :
    (ADDR == OFF_CH_SELECT) ? {12'h000, ch0_sel} :
    (ADDR == OFF_DMA_LEN) ? {13'h0000, dma_len} :
    (ADDR == OFF_STATUS) ? status_rd :
    (ADDR == OFF_RESULT) ? result : 16'h0000;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_first <= RST_CTRL;
      ctrl_second <= RST_CTRL;
      ctrl_third <= RST_CTRL;
      pin_low <= RST_PIN;
      pin_high <= RST_PIN;
      ch0_sel <= RST_CH_SELECT;
      dma_len <= RST_DMA_LEN;
    end else begin
      if (wr_first) ctrl_first <= first_wr;
      if (wr_second) ctrl_second <= WDATA & MASK_CTRL_SECOND;
      if (wr_third) ctrl_third <= WDATA & MASK_CTRL_THIRD;
      if (wr_pin_low) pin_low <= WDATA;
      if (wr_pin_high) pin_high <= WDATA;
      // out-of-range input numbers are clamped to the last input
      if (wr_ch_sel) ch0_sel <= (WDATA[3:0] > 4'hC) ? 4'hC : WDATA[3:0];
      if (wr_dma_len) dma_len <= WDATA[2:0];
    end
  end

  // a clear bit marks an analog pin
  assign PIN_ANALOG = ~pin_low[N_INPUTS-1:0];
  assign VREF_SEL = ctrl_second[B_VREF +: 3];

  // ==========================================================
  // conversion clock and sampling time
  logic [7:0] tad_cnt;
  logic [4:0] samp_tads;
  logic ext_prev;
  wire tad_tick = (tad_cnt == 8'h00);
  wire [4:0] samc_eff = (samc == 5'h00) ? 5'h01 : samc;
  wire auto_end = (samp_tads == samc_eff);
  wire ext_rise = TRIG_EXT && !ext_prev;
  wire sw_end = wr_first && !WDATA[B_SAMP] && samp;
  wire trig_sel =
    (ssrc == TRIG_SOFT) ? sw_end :
    (ssrc == TRIG_EXT_PIN) ? ext_rise :
    (ssrc == TRIG_TMR_A) ? TRIG_TIMER_A :
    (ssrc == TRIG_TMR_B) ? TRIG_TIMER_B :
    (ssrc == TRIG_AUTO) ? auto_end : 1'b0;
  wire trig_end = (st == ST_SAMPLE) && trig_sel;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tad_cnt <= 8'h00;
      samp_tads <= 5'h00;
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= TRIG_EXT;
      tad_cnt <= tad_tick ? adcs : tad_cnt - 8'h01;
      if (st != ST_SAMPLE) samp_tads <= 5'h00;
      else if (tad_tick && !auto_end) samp_tads <= samp_tads + 5'h01;
    end
  end

  // ==========================================================
  // channel sequencing
  logic [1:0] ch_k;
  logic [3:0] cur_input;
  logic [4:0] rate_cnt;
  logic eng_busy;
  logic eng_done;
  logic [11:0] eng_result;
  wire [1:0] last_k = res12 ? 2'h0 :
    (chps == 2'h0) ? 2'h0 : (chps == 2'h1) ? 2'h1 : 2'h3;
  wire last_ch = (ch_k == last_k);
  wire conv_done = (st == ST_CONV) && eng_done;
  wire rate_ok = (rate_cnt == 5'h00);
  wire eng_start = (st == ST_CONV) && !eng_busy && !eng_done && rate_ok;
  wire auto_restart = asam && adon
    && ((st == ST_IDLE) || (conv_done && last_ch));
  wire [3:0] inc_input = (cur_input == 4'hC) ? 4'h0 : cur_input + 4'h1;
  wire next_samp = !adon ? 1'b0 : trig_end ? 1'b0 :
    auto_restart ? 1'b1 : wr_first ? WDATA[B_SAMP] : samp;

  always_comb begin
    next_st = st;
    unique case (st)
      ST_IDLE: if (adon && samp) next_st = ST_SAMPLE;
      ST_SAMPLE: begin
        if (!adon) next_st = ST_IDLE;
        else if (trig_end) next_st = ST_CONV;
      end
      ST_CONV: begin
        if (!adon) next_st = ST_IDLE;
        else if (conv_done && last_ch) next_st = asam ? ST_SAMPLE : ST_IDLE;
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= ST_IDLE;
      samp <= 1'b0;
      ch_k <= 2'h0;
      cur_input <= 4'h0;
      rate_cnt <= 5'h00;
    end else begin
      st <= next_st;
      samp <= next_samp;
      if (trig_end) begin
        ch_k <= 2'h0;
        cur_input <= ch0_sel;
      end else if (conv_done && !last_ch) begin
        ch_k <= ch_k + 2'h1;
        cur_input <= inc_input;
      end
      // spacing between conversion starts bounds the sample rate
      if (eng_start)
        rate_cnt <= (res12 ? MIN_PERIOD_12 : MIN_PERIOD_10) - 5'h01;
      else if (!rate_ok)
        rate_cnt <= rate_cnt - 5'h01;
    end
  end

  assign MUX_INPUT = cur_input;
  assign SH_ROUTE = ch_k;

  // simultaneous: all s/h hold at the trigger; otherwise each keeps
  // tracking until its own conversion begins
  genvar gi;
  generate
    for (gi = 0; gi < N_SH; gi++) begin : g_sh
      wire in_use = (2'(gi) <= last_k);
      assign SH_SAMPLE[gi] = in_use && ((st == ST_SAMPLE)
        || (st == ST_CONV && !simsam_eff && (2'(gi) > ch_k)));
    end
  endgenerate

  sar_engine u_engine (
    .clk(CLK),
    .rst_n(RST_N),
    .start(eng_start),
    .twelve(res12),
    .tad_div(adcs),
    .comp(COMP),
    .busy(eng_busy),
    .done(eng_done),
    .code(DAC_CODE),
    .result(eng_result)
  );

  // ==========================================================
  // result format
  wire [15:0] fmt_int = {4'h0, eng_result};
  wire [15:0] fmt_s10 = {{7{~eng_result[9]}}, eng_result[8:0]};
  wire [15:0] fmt_s12 = {{5{~eng_result[11]}}, eng_result[10:0]};
  wire [15:0] formatted = (form == FMT_SIGNED)
    ? (res12 ? fmt_s12 : fmt_s10) : fmt_int;

  // ==========================================================
  // interrupt flag and dma request
  logic [3:0] conv_cnt;
  logic [6:0] ptr;
  wire pending = DMA_REQ && !DMA_ACK;
  wire flag_event = conv_done && (conv_cnt == per_irq);
  wire [10:0] len_mask = (11'h001 << dma_len) - 11'h001;
  wire [10:0] sg_addr = ({7'h00, cur_input} << dma_len)
    | ({4'h0, ptr} & len_mask);
  wire [10:0] seq_addr = {4'h0, ptr};
  wire [10:0] next_addr = build_order ? seq_addr : sg_addr;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_bit <= 1'b0;
      IRQ_FLAG <= 1'b0;
      overrun <= 1'b0;
      result <= 16'h0000;
      conv_cnt <= 4'h0;
      ptr <= 7'h00;
      DMA_REQ <= 1'b0;
      DMA_ADDR <= 11'h000;
    end else begin
      // hardware set wins over a software clear in the same cycle
      if (conv_done && last_ch) done_bit <= 1'b1;
      else if (eng_start) done_bit <= 1'b0;
      else if (wr_first && !WDATA[B_DONE]) done_bit <= 1'b0;
      if (flag_event) IRQ_FLAG <= 1'b1;
      else if (wr_status && !WDATA[B_IRQ]) IRQ_FLAG <= 1'b0;
      if (conv_done && pending) overrun <= 1'b1;
      else if (wr_status && !WDATA[B_OVR]) overrun <= 1'b0;
      // a held result is not overwritten while dma still owes it
      if (conv_done && !pending) result <= formatted;
      if (conv_done) conv_cnt <= (conv_cnt == per_irq) ? 4'h0
        : conv_cnt + 4'h1;
      if (flag_event && !pending) begin
        DMA_REQ <= 1'b1;
        DMA_ADDR <= next_addr;
        ptr <= ptr + 7'h01;
      end else if (DMA_REQ && DMA_ACK) begin
        DMA_REQ <= 1'b0;
      end
      if (!adon) conv_cnt <= 4'h0;
    end
  end

  assign DMA_DATA = result;

endmodule // sar_adc_ctl

`default_nettype wire

// ---- dv/sar_adc_ctl_properties.sv ----
// port assertions for the converter control block.
// assumes a bind onto sar_adc_ctl; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_ctl_properties (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [adc_ctl_pkg::AW-1:0] ADDR,
  input wire logic [adc_ctl_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [adc_ctl_pkg::DW-1:0] RDATA,
  input wire logic [3:0] MUX_INPUT,
  input wire logic [2:0] VREF_SEL,
  input wire logic [adc_ctl_pkg::N_INPUTS-1:0] PIN_ANALOG,
  input wire logic IRQ_FLAG,
  input wire logic DMA_REQ,
  input wire logic DMA_ACK,
  input wire logic [10:0] DMA_ADDR,
  input wire logic [adc_ctl_pkg::DW-1:0] DMA_DATA
);
  import adc_ctl_pkg::*;
  // ==========================================
  // helpers
  logic [2:0] wr_vref;
  logic [12:0] wr_pins;
  assign wr_vref = WDATA[15:13];
  assign wr_pins = WDATA[12:0];
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // ==========================================
  // properties
  a_req_holds: assert property (DMA_REQ && !DMA_ACK |=> DMA_REQ)
    else $error("dma request dropped before ack");
  // a fresh result may raise a new request at the ack edge; it carries the next
  // buffer address, which can repeat the old one in scatter/gather mode with a zero size field
  a_req_clears: assert property (DMA_REQ && DMA_ACK |=>
    !DMA_REQ || $changed(DMA_ADDR))
    else $error("dma request repeated after ack");
  a_dma_steady: assert property (DMA_REQ && !DMA_ACK |=>
    $stable(DMA_ADDR) && $stable(DMA_DATA))
    else $error("dma address or data moved while pending");
  a_req_flag: assert property ($rose(DMA_REQ) |-> IRQ_FLAG)
    else $error("dma request without interrupt flag");
  a_mux_range: assert property (MUX_INPUT <= 4'hC)
    else $error("input select beyond last input");
  a_rdata_quiet: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data outside read cycle");
  a_vref_write: assert property (WR && ADDR == OFF_CTRL_SECOND |=>
    VREF_SEL == $past(wr_vref))
    else $error("reference select not taken from write");
  a_pin_write: assert property (WR && ADDR == OFF_PIN_LOW |=>
    PIN_ANALOG == ~$past(wr_pins))
    else $error("analog pin map not taken from write");
  a_flag_sticky: assert property (IRQ_FLAG && !(WR && ADDR == OFF_STATUS)
    |=> IRQ_FLAG)
    else $error("interrupt flag lost without clear");
  cover property ($rose(DMA_REQ));
  cover property (DMA_REQ && DMA_ACK);
  cover property (DMA_REQ && !DMA_ACK [*3]);
endmodule // sar_adc_ctl_properties

bind sar_adc_ctl sar_adc_ctl_properties u_props (.CLK(CLK), .RST_N(RST_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .MUX_INPUT(MUX_INPUT), .VREF_SEL(VREF_SEL), .PIN_ANALOG(PIN_ANALOG),
  .IRQ_FLAG(IRQ_FLAG), .DMA_REQ(DMA_REQ), .DMA_ACK(DMA_ACK),
  .DMA_ADDR(DMA_ADDR), .DMA_DATA(DMA_DATA));
`default_nettype wire

// ---- dv/dma_partner.sv ----
// dma controller model: acks each request after a set delay, logs it.
// assumes requests are levels held until the one-cycle ack.
`timescale 1ns/1ps
`default_nettype none

module dma_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] delay,
  input wire logic req,
  input wire logic [10:0] addr,
  input wire logic [15:0] data,
  output logic ack
);
  logic [4:0] wait_cnt;
  logic [26:0] got [$];
  // ==========================================
  // slow delays leave the result unread past the next conversion
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      wait_cnt <= 5'h00;
    end else if (ack) begin
      ack <= 1'b0;
      wait_cnt <= 5'h00;
    end else if (req && wait_cnt >= delay) begin
      ack <= 1'b1;
      got.push_back({addr, data});
    end else if (req) begin
      wait_cnt <= wait_cnt + 5'h01;
    end
  end
endmodule // dma_partner
`default_nettype wire

// ---- dv/sar_adc_ctl_tb.sv ----
// self-checking bench: register port, conversions, dma addressing.
// assumes an ideal comparator and the dma_partner model.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_ctl_tb;
  import adc_ctl_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [11:0] vin = 12'h000;
  logic [4:0] dly = 5'h00;
  logic tw_now = 1'b0;
  logic code_q = 1'b0;
  logic ext = 1'b0;
  logic tma = 1'b0;
  logic tmb = 1'b0;
  logic bad_sh;
  logic bad_rate;
  int checked = 0;
  int miscompares = 0;
  int cyc = 0;
  int starts;
  int last_start;
  int at_req;
  wire [15:0] RDATA;
  wire [11:0] DAC_CODE;
  wire [3:0] SH_SAMPLE;
  wire [3:0] MUX_INPUT;
  wire [1:0] SH_ROUTE;
  wire [2:0] VREF_SEL;
  wire [12:0] PIN_ANALOG;
  wire IRQ_FLAG;
  wire DMA_REQ;
  wire DMA_ACK;
  wire [10:0] DMA_ADDR;
  wire [15:0] DMA_DATA;
  wire COMP = (vin >= DAC_CODE);

  sar_adc_ctl DUT (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .COMP(COMP), .DAC_CODE(DAC_CODE),
    .SH_SAMPLE(SH_SAMPLE), .MUX_INPUT(MUX_INPUT), .SH_ROUTE(SH_ROUTE),
    .VREF_SEL(VREF_SEL), .PIN_ANALOG(PIN_ANALOG), .TRIG_EXT(ext),
    .TRIG_TIMER_A(tma), .TRIG_TIMER_B(tmb), .IRQ_FLAG(IRQ_FLAG),
    .DMA_REQ(DMA_REQ), .DMA_ACK(DMA_ACK), .DMA_ADDR(DMA_ADDR),
    .DMA_DATA(DMA_DATA));
  dma_partner u_dma (.clk(CLK), .rst_n(RST_N), .delay(dly), .req(DMA_REQ),
    .addr(DMA_ADDR), .data(DMA_DATA), .ack(DMA_ACK));

  always #50 CLK = ~CLK;

  // ==========================================
  // helpers
  function automatic logic [15:0] fmt(input logic [11:0] d,
    input logic tw, input logic sg);
    logic [15:0] z;
    z = tw ? {4'h0, d} : {6'h00, d[9:0]};
    if (sg && tw) z[15:11] = {5{~d[11]}};
    if (sg && !tw) z[15:9] = {7{~d[9]}};
    return z;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp,
    input string what);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 check(RDATA, exp, what);
  endtask

  task automatic do_reset;
    RST_N <= 1'b0;
    repeat (10) @(posedge CLK);
    u_dma.got.delete();
    RST_N <= 1'b1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // conversion starts, their spacing, s/h use; timeout
  always @(posedge CLK) begin
    cyc++;
    if (DAC_CODE != 12'h000 && !code_q) begin
      if (cyc - last_start < (tw_now ? 20 : 10)) bad_rate = 1'b1;
      starts++;
      last_start = cyc;
    end
    code_q = (DAC_CODE != 12'h000);
    if (DMA_REQ && at_req < 0) at_req = starts;
    if (tw_now && SH_SAMPLE[3:1] !== 3'b000) bad_sh = 1'b1;
    if (cyc == 60000) begin
      miscompares++;
      $display("ERROR %0t run did not finish", $time);
      print_verdict();
    end
  end

  // ==========================================
  // one continuous run with dma, random setup
  task automatic run(input int it);
    logic sg, bl;
    logic [1:0] sm;
    logic [2:0] ln;
    logic [3:0] inp;
    logic [12:0] pins;
    logic [10:0] ea;
    int n;
    tw_now = 1'($urandom);
    sg = 1'($urandom);
    bl = 1'($urandom);
    sm = 2'($urandom % 3);
    ln = 3'(1 + $urandom % 3);
    inp = 4'($urandom % 13);
    pins = 13'($urandom);
    vin = tw_now ? 12'($urandom) : {2'b00, 10'($urandom)};
    do_reset;
    starts = 0;
    last_start = -100;
    at_req = -1;
    bad_sh = 1'b0;
    bad_rate = 1'b0;
    dly <= it[0] ? 5'h1E : 5'h00;
    wr(OFF_PIN_LOW, {3'h0, pins});
    #1 check({3'h0, PIN_ANALOG}, {3'h0, ~pins}, "pin map");
    wr(OFF_CH_SELECT, {12'h000, inp});
    wr(OFF_DMA_LEN, {13'h0000, ln});
    wr(OFF_CTRL_SECOND, {3'h5, 3'h0, {tw_now, 1'b0}, 4'h0, sm, 2'h0});
    wr(OFF_CTRL_THIRD, 16'h0100);
    wr(OFF_CTRL_FIRST, {1'b1, 2'b00, bl, 1'b0, tw_now, 1'b0, sg, 3'h7,
      2'b00, 1'b1, 2'b00});
    n = 0;
    while (u_dma.got.size() < 3 && n < 4000) begin
      @(posedge CLK);
      n++;
    end
    wr(OFF_CTRL_FIRST, 16'h0000);
    repeat (60) @(posedge CLK);
    check(16'(u_dma.got.size() >= 3), 16'h0001, "dma count");
    for (int k = 0; k < 3 && k < u_dma.got.size(); k++) begin
      ea = bl ? 11'(k) : 11'((inp << ln) | (k & ((1 << ln) - 1)));
      check({5'h00, u_dma.got[k][26:16]}, {5'h00, ea}, "addr");
      check(u_dma.got[k][15:0], fmt(vin, tw_now, sg), "data");
    end
    check(16'(at_req), 16'(sm + 1), "conversions per flag");
    check({15'h0000, bad_rate}, 16'h0000, "rate");
    check({15'h0000, bad_sh}, 16'h0000, "one s/h");
    rd(OFF_RESULT, fmt(vin, tw_now, sg), "result");
    check({15'h0000, IRQ_FLAG}, 16'h0001, "flag pin");
    rd(OFF_STATUS, {14'h0000, it[0], 1'b1}, "status");
    wr(OFF_STATUS, 16'h0000);
    rd(OFF_STATUS, 16'h0000, "status clear");
    $display("run %0d done", it);
  endtask

  // ==========================================
  // four s/h sampled together, one sequence per trigger source other than auto
  task automatic manual(input logic [2:0] src);
    logic [3:0] inp;
    logic [15:0] cfg;
    inp = 4'($urandom % 13);
    cfg = 16'h8008 | {8'h00, src, 5'h00};
    tw_now = 1'b0;
    vin = {2'b00, 10'($urandom)};
    do_reset;
    dly <= 5'h00;
    wr(OFF_CTRL_SECOND, 16'h030C);
    wr(OFF_CTRL_THIRD, 16'h0100);
    wr(OFF_CH_SELECT, {12'h000, inp});
    wr(OFF_CTRL_FIRST, cfg);
    wr(OFF_CTRL_FIRST, cfg | 16'h0002);
    repeat (4) @(posedge CLK);
    #1 check({12'h000, SH_SAMPLE}, 16'h000F, "all tracking");
    @(posedge CLK);
    if (src == TRIG_SOFT) begin
      wr(OFF_CTRL_FIRST, cfg);
    end else begin
      ext <= (src == TRIG_EXT_PIN);
      tma <= (src == TRIG_TMR_A);
      tmb <= (src == TRIG_TMR_B);
      @(posedge CLK);
      ext <= 1'b0;
      tma <= 1'b0;
      tmb <= 1'b0;
    end
    repeat (3) @(posedge CLK);
    #1 check({12'h000, SH_SAMPLE}, 16'h0000, "all holding");
    repeat (80) @(posedge CLK);
    #1 check({12'h000, MUX_INPUT}, 16'((inp + 3) % 13), "last in");
    check({14'h0000, SH_ROUTE}, 16'h0003, "last s/h");
    check({15'h0000, IRQ_FLAG}, 16'h0001, "flag after four");
    check(16'(u_dma.got.size()), 16'h0001, "one transfer");
    check({5'h00, u_dma.got[0][26:16]}, 16'((inp + 3) % 13), "sg");
    check(u_dma.got[0][15:0], fmt(vin, 1'b0, 1'b0), "plain");
    rd(OFF_CTRL_FIRST, cfg | 16'h0001, "done");
    $display("trigger %0d done", src);
  endtask

  initial begin
    void'($urandom(32'hA959));
    do_reset;
    for (int a = 0; a < 10; a++) rd(4'(a), 16'h0000, "reset value");
    check({3'h0, PIN_ANALOG}, 16'h1FFF, "pins at reset");
    wr(OFF_CTRL_SECOND, 16'hFFFF);
    rd(OFF_CTRL_SECOND, MASK_CTRL_SECOND, "second");
    wr(OFF_CTRL_THIRD, 16'hFFFF);
    rd(OFF_CTRL_THIRD, MASK_CTRL_THIRD, "third");
    wr(OFF_CTRL_FIRST, 16'h37EC);
    rd(OFF_CTRL_FIRST, 16'h37E4, "first");
    wr(OFF_CTRL_FIRST, 16'h8000);
    wr(OFF_CTRL_FIRST, 16'h8400);
    rd(OFF_CTRL_FIRST, 16'h8000, "resolution while on");
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000, "unmapped");
    wr(OFF_CH_SELECT, 16'h000F);
    rd(OFF_CH_SELECT, 16'h000C, "input clamp");
    $display("registers done");
    for (int i = 0; i < 6; i++) run(i);
    for (int s = 0; s < 4; s++) manual(s == 3 ? TRIG_TMR_B : 3'(s));
    print_verdict();
  end
endmodule // sar_adc_ctl_tb
`default_nettype wire
